// [src/alu_skip_core.sv]
// Accumulator datapath for rotate, subtract, skip, set, swap, table and xor operations
//
// Contract
// - Rotate right through carry into accumulator
// - Borrow subtract: acc + ~m + C, four flags
// - Subtract memory: acc + ~m + 1, four flags
// - Immediate subtract into acc, carry only
// - Skip discards prefetch, adds dummy cycle
// - Decrement to memory, skip on zero
// - Decrement into acc, skip on zero
// - Increment to memory, skip on zero
// - Increment into acc, skip on zero
// - Fill byte with ones, no flags
// - Set one bit, no flags
// - Skip when selected bit is one
// - Skip when byte or bit is zero
// - Copy to acc, skip on zero
// - Swap nibbles in memory, no flags
// - Swapped byte to acc, memory kept
// - Table read current page, split word
// - Table read last page, split word
// - Xor to acc or memory, zero only
// - Immediate xor into acc, zero only
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module alu_skip_core (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             busy,
    output logic             prog_rd,
    output logic      [10:0] prog_addr,
    input  wire logic [13:0] prog_data
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Returns {ov, ac, c, sum}
    function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] full;
        logic [4:0] lo;
        logic       c_in7;
        full  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        c_in7 = a[7] ^ b[7] ^ full[7];
        return {c_in7 ^ full[8], lo[4], full[8], full[7:0]};
    endfunction

    function automatic logic [7:0] nib_swap(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    alu_skip_pkg::state_t state_q;
    alu_skip_pkg::op_t    op_q;
    logic [2:0]           bit_q;
    logic [3:0]           msel_op_q;
    logic [7:0]           imm_q;
    logic [7:0]           acc_q;
    logic                 c_q;
    logic                 ac_q;
    logic                 z_q;
    logic                 ov_q;
    logic                 skip_q;
    logic [10:0]          pc_q;
    logic [7:0]           lptr_q;
    logic [5:0]           lupper_q;
    logic [3:0]           msel_q;
    logic [7:0]           mem_q [alu_skip_pkg::MEM_DEPTH];
    logic                 rd_done_q;
    logic [31:0]          readdata_q;
    logic [10:0]          prog_addr_q;

    logic                 idle;
    logic                 wr_acc;
    logic                 in_exec;
    logic [7:0]           m_opnd;
    logic                 m_bit;
    logic [7:0]           res;
    logic                 to_acc;
    logic                 to_mem;
    logic                 skip;
    logic                 tbl;
    logic [7:0]           alu_b;
    logic                 alu_ci;
    logic [10:0]          sum;
    logic                 c_d;
    logic                 ac_d;
    logic                 z_d;
    logic                 ov_d;

    assign idle    = (state_q == alu_skip_pkg::ST_IDLE);
    assign in_exec = ce && (state_q == alu_skip_pkg::ST_EXEC);
    assign wr_acc  = ce && write && idle;
    assign m_opnd  = mem_q[msel_op_q];
    assign m_bit   = m_opnd[bit_q];
    assign sum     = add8(acc_q, alu_b, alu_ci);

    // ------------------------------------------------------------------
    // Avalon slave
    // ------------------------------------------------------------------
    // Writes stall while an operation runs; reads answer one cycle later
    assign waitrequest = !ce || (write && !idle) || (read && !rd_done_q);
    assign readdata    = readdata_q;
    assign busy        = !idle;
    assign prog_rd     = (state_q == alu_skip_pkg::ST_TABLE);
    assign prog_addr   = prog_addr_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_done_q  <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else if (ce) begin
            rd_done_q <= read && !rd_done_q;
            if (read && !rd_done_q) begin
                case (address)
                    alu_skip_pkg::OFS_OPER:   readdata_q <= {imm_q, 4'h0, msel_op_q, 5'h00, bit_q, 3'h0, op_q};
                    alu_skip_pkg::OFS_ACC:    readdata_q <= {24'h000000, acc_q};
                    alu_skip_pkg::OFS_STATUS: readdata_q <= {22'h000000, skip_q, busy, 4'h0, ov_q, z_q, ac_q, c_q};
                    alu_skip_pkg::OFS_PC:     readdata_q <= {21'h000000, pc_q};
                    alu_skip_pkg::OFS_LPTR:   readdata_q <= {24'h000000, lptr_q};
                    alu_skip_pkg::OFS_LUPPER: readdata_q <= {26'h0000000, lupper_q};
                    alu_skip_pkg::OFS_MSEL:   readdata_q <= {28'h0000000, msel_q};
                    alu_skip_pkg::OFS_MDATA:  readdata_q <= {24'h000000, mem_q[msel_q]};
                    default:                  readdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Operation latch and sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            op_q      <= alu_skip_pkg::OP_NONE;
            bit_q     <= 3'h0;
            msel_op_q <= alu_skip_pkg::MSEL_RST;
            imm_q     <= alu_skip_pkg::BYTE_RST;
        end else if (wr_acc && address == alu_skip_pkg::OFS_OPER) begin
            op_q      <= alu_skip_pkg::op_t'(writedata[alu_skip_pkg::OPER_OP_LSB +: 5]);
            bit_q     <= writedata[alu_skip_pkg::OPER_BIT_LSB +: 3];
            msel_op_q <= writedata[alu_skip_pkg::OPER_MSEL_LSB +: 4];
            imm_q     <= writedata[alu_skip_pkg::OPER_IMM_LSB +: 8];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= alu_skip_pkg::ST_IDLE;
        end else if (ce) begin
            case (state_q)
                alu_skip_pkg::ST_IDLE: begin
                    if (wr_acc && address == alu_skip_pkg::OFS_OPER) begin
                        state_q <= alu_skip_pkg::ST_EXEC;
                    end
                end
                alu_skip_pkg::ST_EXEC: begin
                    if (skip) begin
                        state_q <= alu_skip_pkg::ST_DUMMY;
                    end else if (tbl) begin
                        state_q <= alu_skip_pkg::ST_TABLE;
                    end else begin
                        state_q <= alu_skip_pkg::ST_IDLE;
                    end
                end
                alu_skip_pkg::ST_DUMMY: state_q <= alu_skip_pkg::ST_IDLE;
                alu_skip_pkg::ST_TABLE: state_q <= alu_skip_pkg::ST_IDLE;
                default:                state_q <= alu_skip_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Execute decode
    // ------------------------------------------------------------------
    always_comb begin
        res    = acc_q;
        to_acc = 1'b0;
        to_mem = 1'b0;
        skip   = 1'b0;
        tbl    = 1'b0;
        alu_b  = ~m_opnd;
        alu_ci = 1'b1;
        c_d    = c_q;
        ac_d   = ac_q;
        z_d    = z_q;
        ov_d   = ov_q;
        case (op_q)
            alu_skip_pkg::OP_ROT_RIGHT_CARRY: begin
                res    = {c_q, m_opnd[7:1]};
                to_acc = 1'b1;
                c_d    = m_opnd[0];
            end
            alu_skip_pkg::OP_BORROW_SUB_ACC, alu_skip_pkg::OP_BORROW_SUB_MEM,
            alu_skip_pkg::OP_MINUS_OPERAND, alu_skip_pkg::OP_MINUS_TO_MEM: begin
                alu_ci = (op_q == alu_skip_pkg::OP_BORROW_SUB_ACC ||
                          op_q == alu_skip_pkg::OP_BORROW_SUB_MEM) ? c_q : 1'b1;
                res    = sum[7:0];
                to_acc = (op_q == alu_skip_pkg::OP_BORROW_SUB_ACC || op_q == alu_skip_pkg::OP_MINUS_OPERAND);
                to_mem = !to_acc;
                c_d    = sum[8];
                ac_d   = sum[9];
                ov_d   = sum[10];
                z_d    = (sum[7:0] == alu_skip_pkg::BYTE_RST);
            end
            alu_skip_pkg::OP_MINUS_IMM: begin
                alu_b  = ~imm_q;
                res    = sum[7:0];
                to_acc = 1'b1;
                c_d    = sum[8];
            end
            alu_skip_pkg::OP_DEC_SKIP_ZERO, alu_skip_pkg::OP_DEC_SKIP_ACC: begin
                res    = m_opnd - 8'h01;
                to_acc = (op_q == alu_skip_pkg::OP_DEC_SKIP_ACC);
                to_mem = !to_acc;
                skip   = (res == alu_skip_pkg::BYTE_RST);
            end
            alu_skip_pkg::OP_INC_SKIP_ZERO, alu_skip_pkg::OP_INC_SKIP_ACC: begin
                res    = m_opnd + 8'h01;
                to_acc = (op_q == alu_skip_pkg::OP_INC_SKIP_ACC);
                to_mem = !to_acc;
                skip   = (res == alu_skip_pkg::BYTE_RST);
            end
            alu_skip_pkg::OP_FILL_ONES: begin
                res    = alu_skip_pkg::ALL_ONES;
                to_mem = 1'b1;
            end
            alu_skip_pkg::OP_SET_BIT: begin
                res    = m_opnd | (8'h01 << bit_q);
                to_mem = 1'b1;
            end
            alu_skip_pkg::OP_SKIP_BIT_SET:  skip = m_bit;
            alu_skip_pkg::OP_SKIP_ON_ZERO:  skip = (m_opnd == alu_skip_pkg::BYTE_RST);
            alu_skip_pkg::OP_SKIP_BIT_ZERO: skip = !m_bit;
            alu_skip_pkg::OP_COPY_SKIP_ZERO: begin
                res    = m_opnd;
                to_acc = 1'b1;
                skip   = (m_opnd == alu_skip_pkg::BYTE_RST);
            end
            alu_skip_pkg::OP_NIBBLE_EXCHANGE: begin
                res    = nib_swap(m_opnd);
                to_mem = 1'b1;
            end
            alu_skip_pkg::OP_NIBBLE_TO_ACC: begin
                res    = nib_swap(m_opnd);
                to_acc = 1'b1;
            end
            alu_skip_pkg::OP_LOOKUP_CURRENT, alu_skip_pkg::OP_LOOKUP_LAST: tbl = 1'b1;
            alu_skip_pkg::OP_EXCLUSIVE_OR, alu_skip_pkg::OP_EXCLUSIVE_TO_MEM: begin
                res    = acc_q ^ m_opnd;
                to_acc = (op_q == alu_skip_pkg::OP_EXCLUSIVE_OR);
                to_mem = !to_acc;
                z_d    = (res == alu_skip_pkg::BYTE_RST);
            end
            alu_skip_pkg::OP_EXCLUSIVE_IMM: begin
                res    = acc_q ^ imm_q;
                to_acc = 1'b1;
                z_d    = (res == alu_skip_pkg::BYTE_RST);
            end
            default: res = acc_q;
        endcase
    end

    // ------------------------------------------------------------------
    // Accumulator and flags
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_q <= alu_skip_pkg::BYTE_RST;
        end else if (in_exec && to_acc) begin
            acc_q <= res;
        end else if (wr_acc && address == alu_skip_pkg::OFS_ACC) begin
            acc_q <= writedata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            c_q  <= 1'b0;
            ac_q <= 1'b0;
            z_q  <= 1'b0;
            ov_q <= 1'b0;
        end else if (in_exec) begin
            c_q  <= c_d;
            ac_q <= ac_d;
            z_q  <= z_d;
            ov_q <= ov_d;
        end else if (wr_acc && address == alu_skip_pkg::OFS_STATUS) begin
            c_q  <= writedata[alu_skip_pkg::ST_C_BIT];
            ac_q <= writedata[alu_skip_pkg::ST_AC_BIT];
            z_q  <= writedata[alu_skip_pkg::ST_Z_BIT];
            ov_q <= writedata[alu_skip_pkg::ST_OV_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            skip_q <= 1'b0;
        end else if (in_exec) begin
            skip_q <= skip;
        end
    end

    // ------------------------------------------------------------------
    // Program counter and table access
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pc_q <= alu_skip_pkg::PC_RST;
        end else if (ce && (in_exec || state_q == alu_skip_pkg::ST_DUMMY)) begin
            pc_q <= pc_q + alu_skip_pkg::PC_STEP;
        end else if (wr_acc && address == alu_skip_pkg::OFS_PC) begin
            pc_q <= writedata[10:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prog_addr_q <= alu_skip_pkg::PC_RST;
        end else if (in_exec && tbl) begin
            prog_addr_q <= {(op_q == alu_skip_pkg::OP_LOOKUP_LAST) ? alu_skip_pkg::LAST_PAGE : pc_q[10:8], lptr_q};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lptr_q   <= alu_skip_pkg::BYTE_RST;
            lupper_q <= alu_skip_pkg::UPPER_RST;
            msel_q   <= alu_skip_pkg::MSEL_RST;
        end else if (ce) begin
            if (prog_rd) begin
                lupper_q <= prog_data[13:8];
            end
            if (wr_acc && address == alu_skip_pkg::OFS_LPTR) begin
                lptr_q <= writedata[7:0];
            end
            if (wr_acc && address == alu_skip_pkg::OFS_MSEL) begin
                msel_q <= writedata[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < alu_skip_pkg::MEM_DEPTH; i++) begin
                mem_q[i] <= alu_skip_pkg::BYTE_RST;
            end
        end else if (in_exec && to_mem) begin
            mem_q[msel_op_q] <= res;
        end else if (ce && prog_rd) begin
            mem_q[msel_op_q] <= prog_data[7:0];
        end else if (wr_acc && address == alu_skip_pkg::OFS_MDATA) begin
            mem_q[msel_q] <= writedata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence seq_dummy_then_idle;
        state_q == alu_skip_pkg::ST_DUMMY ##1 state_q == alu_skip_pkg::ST_IDLE;
    endsequence

    sequence seq_table_then_idle;
        prog_rd ##1 state_q == alu_skip_pkg::ST_IDLE;
    endsequence

    AST_SKIP_TWO_CYCLES: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        in_exec && skip |=> seq_dummy_then_idle) else $error("skip did not take a dummy cycle");
    AST_NOSKIP_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        in_exec && !skip && !tbl |=> idle) else $error("plain operation took more than one cycle");
    AST_DUMMY_IS_NOP: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        state_q == alu_skip_pkg::ST_DUMMY |=> $stable(acc_q) && $stable(c_q) && $stable(z_q)
        && pc_q == $past(pc_q) + alu_skip_pkg::PC_STEP) else $error("dummy cycle changed state");
    AST_TABLE_TWO_CYCLES: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        in_exec && tbl |=> seq_table_then_idle) else $error("table read not two cycles");
    AST_LAST_PAGE: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        prog_rd && op_q == alu_skip_pkg::OP_LOOKUP_LAST |-> prog_addr[10:8] == alu_skip_pkg::LAST_PAGE
        && prog_addr[7:0] == lptr_q) else $error("last page address wrong");
    AST_TABLE_SPLIT: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        prog_rd |=> lupper_q == $past(prog_data[13:8]) && mem_q[msel_op_q] == $past(prog_data[7:0]))
        else $error("table word not split");
    AST_ROTATE: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        in_exec && op_q == alu_skip_pkg::OP_ROT_RIGHT_CARRY |=> acc_q == {$past(c_q), $past(m_opnd[7:1])}
        && c_q == $past(m_opnd[0])) else $error("rotate result wrong");
    AST_FILL_ONES: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        in_exec && op_q == alu_skip_pkg::OP_FILL_ONES |=> m_opnd == alu_skip_pkg::ALL_ONES && $stable(c_q)
        && $stable(z_q)) else $error("fill did not write ones");
    AST_DEC_SKIP: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        in_exec && op_q == alu_skip_pkg::OP_DEC_SKIP_ZERO && m_opnd == 8'h01 |=> m_opnd == 8'h00
        && state_q == alu_skip_pkg::ST_DUMMY) else $error("decrement skip wrong");
    AST_XOR_ZERO_ONLY: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        in_exec && op_q == alu_skip_pkg::OP_EXCLUSIVE_OR |=> acc_q == ($past(acc_q) ^ $past(m_opnd))
        && $stable(c_q) && z_q == (acc_q == 8'h00)) else $error("xor result or flags wrong");
endmodule // alu_skip_core

// [src/alu_skip_pkg.sv]
// Constants, field layouts and types shared by the skip and table datapath
package alu_skip_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_OPER   = 5'h00;
    localparam logic [4:0] OFS_ACC    = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_PC     = 5'h0C;
    localparam logic [4:0] OFS_LPTR   = 5'h10;
    localparam logic [4:0] OFS_LUPPER = 5'h14;
    localparam logic [4:0] OFS_MSEL   = 5'h18;
    localparam logic [4:0] OFS_MDATA  = 5'h1C;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OPER_OP_LSB   = 0;
    localparam int OPER_BIT_LSB  = 8;
    localparam int OPER_MSEL_LSB = 16;
    localparam int OPER_IMM_LSB  = 24;
    localparam int ST_C_BIT      = 0;
    localparam int ST_AC_BIT     = 1;
    localparam int ST_Z_BIT      = 2;
    localparam int ST_OV_BIT     = 3;
    localparam int ST_BUSY_BIT   = 8;
    localparam int ST_SKIP_BIT   = 9;
    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int          MEM_DEPTH  = 16;
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [7:0]  ALL_ONES   = 8'hFF;
    localparam logic [10:0] PC_RST     = 11'h000;
    localparam logic [10:0] PC_STEP    = 11'h001;
    localparam logic [2:0]  LAST_PAGE  = 3'h7;
    localparam logic [5:0]  UPPER_RST  = 6'h00;
    localparam logic [3:0]  MSEL_RST   = 4'h0;

    typedef enum logic [4:0] {
        OP_NONE             = 5'h00, OP_ROT_RIGHT_CARRY = 5'h01,
        OP_BORROW_SUB_ACC   = 5'h02, OP_BORROW_SUB_MEM  = 5'h03,
        OP_MINUS_OPERAND    = 5'h04, OP_MINUS_TO_MEM    = 5'h05,
        OP_MINUS_IMM        = 5'h06, OP_DEC_SKIP_ZERO   = 5'h07,
        OP_DEC_SKIP_ACC     = 5'h08, OP_INC_SKIP_ZERO   = 5'h09,
        OP_INC_SKIP_ACC     = 5'h0A, OP_FILL_ONES       = 5'h0B,
        OP_SET_BIT          = 5'h0C, OP_SKIP_BIT_SET    = 5'h0D,
        OP_SKIP_ON_ZERO     = 5'h0E, OP_SKIP_BIT_ZERO   = 5'h0F,
        OP_COPY_SKIP_ZERO   = 5'h10, OP_NIBBLE_EXCHANGE = 5'h11,
        OP_NIBBLE_TO_ACC    = 5'h12, OP_LOOKUP_CURRENT  = 5'h13,
        OP_LOOKUP_LAST      = 5'h14, OP_EXCLUSIVE_OR    = 5'h15,
        OP_EXCLUSIVE_TO_MEM = 5'h16, OP_EXCLUSIVE_IMM   = 5'h17
    } op_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_EXEC  = 4'b0010,
        ST_DUMMY = 4'b0100,
        ST_TABLE = 4'b1000
    } state_t;
endpackage

// [test/mcu_alu_skip_table_ops_tb_top.sv]
// Self-checking bench for the skip, table and arithmetic datapath
`timescale 1ns/1ps
module mcu_alu_skip_table_ops_tb_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        ref_clk    = 1'b0;
    logic        reset      = 1'b1;
    logic        ce         = 1'b1;
    logic [4:0]  address    = 5'h00;
    logic        read       = 1'b0;
    logic        write      = 1'b0;
    logic [31:0] writedata  = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        busy;
    logic        prog_rd;
    logic [10:0] prog_addr;
    logic [13:0] prog_data;
    logic [31:0] seed       = 32'h0000119F;
    logic [31:0] exp_q [$];
    logic [5:0]  up_x       = 6'h00;
    logic [31:0] r0;
    logic [31:0] r1;
    int          n_mismatch = 0;
    int          num_checks = 0;
    // Entry: op, bit, mem, acc, status in, acc out, mem out, {skip, flags out}
    localparam logic [63:0] CASES [28] = '{
        64'h01_00_80_00_01_C0_80_00, 64'h02_00_01_80_01_7F_01_09, 64'h03_00_05_05_01_05_00_07,
        64'h04_00_05_03_0F_FE_05_00, 64'h05_00_03_05_00_05_02_03, 64'h06_00_01_00_0E_FF_01_0E,
        64'h07_00_01_00_00_00_00_80, 64'h08_00_02_00_00_01_02_00, 64'h09_00_FF_00_00_00_00_80,
        64'h0A_00_FF_00_00_00_FF_80, 64'h0B_00_12_00_05_00_FF_05, 64'h0C_07_01_00_00_00_81_00,
        64'h0D_03_08_00_00_00_08_80, 64'h0D_03_F7_00_00_00_F7_00, 64'h0E_00_00_00_00_00_00_80,
        64'h0E_00_01_00_00_00_01_00, 64'h0F_00_FE_00_00_00_FE_80, 64'h0F_00_01_00_00_00_01_00,
        64'h10_00_00_55_00_00_00_80, 64'h10_00_07_55_00_07_07_00,
        64'h11_00_A5_00_0F_00_5A_0F, 64'h12_00_3C_00_00_C3_3C_00, 64'h13_00_11_00_00_00_40_00,
        64'h14_00_11_22_00_22_40_00,
        64'h15_00_F0_F0_00_00_F0_04, 64'h16_00_F0_0F_0F_0F_FF_0B, 64'h00_00_11_22_03_22_11_03,
        64'h1F_00_11_22_03_22_11_03};

    // Program word echoes its address; idle bus shows all ones
    assign prog_data = prog_rd ? {3'h5, prog_addr} : 14'h3FFF;

    alu_skip_core dut (.ref_clk(ref_clk), .reset(reset), .ce(ce), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .busy(busy), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // Avalon master, expectation noted for reads
    // ------------------------------------------------------------------
    task automatic bus(input logic rd, input logic [4:0] ad, input logic [31:0] d);
        if (rd) exp_q.push_back(d);
        read      <= rd;
        write     <= ~rd;
        address   <= ad;
        writedata <= rd ? 32'h0 : d;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) chk(readdata, exp_q.pop_front());
        if (prog_rd === 1'b1) chk({31'h0, busy}, 32'h1);
    end

    task automatic run(input logic [63:0] e);
        logic [3:0] idx;
        r0  = rnd();
        idx = r0[3:0];
        bus(1'b0, alu_skip_pkg::OFS_MSEL, {28'h0, idx});
        bus(1'b0, alu_skip_pkg::OFS_MDATA, {24'h0, e[47:40]});
        bus(1'b0, alu_skip_pkg::OFS_ACC, {24'h0, e[39:32]});
        bus(1'b0, alu_skip_pkg::OFS_STATUS, {24'h0, e[31:24]});
        bus(1'b0, alu_skip_pkg::OFS_PC, 32'h0);
        bus(1'b0, alu_skip_pkg::OFS_OPER, {e[47:40], 4'h0, idx, 5'h00, e[50:48], 3'h0, e[60:56]});
        // Stalls until the operation is over
        bus(1'b0, alu_skip_pkg::OFS_MSEL, {28'h0, idx});
        if (e[63:56] == 8'h13) up_x = 6'h28;
        if (e[63:56] == 8'h14) up_x = 6'h2F;
        bus(1'b1, alu_skip_pkg::OFS_ACC, {24'h0, e[23:16]});
        bus(1'b1, alu_skip_pkg::OFS_MDATA, {24'h0, e[15:8]});
        bus(1'b1, alu_skip_pkg::OFS_STATUS, {22'h0, e[7], 5'h00, e[3:0]});
        bus(1'b1, alu_skip_pkg::OFS_PC, 32'h1 + 32'(e[7]));
        bus(1'b1, alu_skip_pkg::OFS_LUPPER, {26'h0, up_x});
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 8; i++) bus(1'b1, 5'(i * 4), 32'h0);
        bus(1'b0, 5'h02, 32'hFF);
        bus(1'b1, 5'h02, 32'h0);
        bus(1'b0, alu_skip_pkg::OFS_LPTR, 32'h40);
        for (int i = 0; i < 28; i++) run(CASES[i]);
        for (int i = 0; i < 4; i++) begin
            r0 = rnd();
            r1 = (i == 0) ? r0 : rnd();
            run({8'h17, 8'h00, r1[7:0], r0[7:0], 8'h0B, r0[7:0] ^ r1[7:0], r1[7:0], 5'h01, r0[7:0] == r1[7:0], 2'h3});
        end
        end_of_test();
    end

    initial begin
        #80000;
        n_mismatch++;
        end_of_test();
    end
endmodule // mcu_alu_skip_table_ops_tb_top
